// ==== dv/cold_load_inrush_detector_test.sv ====
// Self-checking bench for the cold load and inrush detector.
// Assumes shortened window and millisecond counts for speed.
`timescale 1ns/1ps
module cold_load_inrush_detector_test;
    import cold_load_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

    logic CLK = 0, SYS_RST = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, seed = 32'h2dc0_88dc;
    logic [2:0][15:0] cmd_cur = '0;
    logic [2:0][7:0] cmd_harm = '0;
    wire [15:0] c1, c2, c3;
    wire [7:0] h1, h2, h3;
    wire hv, cl_det, ir_det, cl_out, cl_blk, ir_out, ir_blk, irq;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [5:0] det_vec = {cl_det, cl_out, cl_blk, ir_det, ir_out, ir_blk};
    logic [33:0] exp_r[$], exp_v;
    logic [1:0] exp_b[$], exp_w;
    int err_total = 0, n_checks = 0;
    logic [7:0] thr_t [5] = '{8'h14, 8'h14, 8'h14, 8'h14, 8'h00};
    logic [23:0] hm_t [5] = '{24'h14_1415, 24'h14_1514, 24'h15_1414,
                              24'h14_1414, 24'h00_0000};

    // Clock at 200 MHz
    initial begin
        forever #2.5 CLK = ~CLK;
    end

    phase_source_model #(.CYCLE_LEN(8)) i_src (.clk(CLK),
        .cmd_cur(cmd_cur), .cmd_harm(cmd_harm), .cur1(c1), .cur2(c2),
        .cur3(c3), .harm1(h1), .harm2(h2), .harm3(h3), .harm_valid(hv));

    cold_load_inrush_detector #(.WIN_CYCLES(20), .MSEC_CYCLES(4)) i_dut (
        .CLK(CLK), .SYS_RST(SYS_RST), .PHASE1_CURRENT(c1),
        .PHASE2_CURRENT(c2), .PHASE3_CURRENT(c3), .PHASE1_HARM_PCT(h1),
        .PHASE2_HARM_PCT(h2), .PHASE3_HARM_PCT(h3), .HARM_VALID(hv),
        .COLD_LOAD_DETECT(cl_det), .INRUSH_DETECT(ir_det),
        .COLD_LOAD_OUT_MATRIX(cl_out), .COLD_LOAD_BLOCK_MATRIX(cl_blk),
        .INRUSH_OUT_MATRIX(ir_out), .INRUSH_BLOCK_MATRIX(ir_blk),
        .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc

    // Raise one phase to v, others random below idle (ph 3: none)
    task automatic put(input int ph, input logic [15:0] v);
        @(posedge CLK);
        for (int k = 0; k < 3; k++) begin
            cmd_cur[k] <= (k == ph) ? v : 16'(xs() & 32'h0000_000F);
        end
    endtask : put

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        bit done = 0;
        exp_b.push_back(r);
        @(posedge CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge CLK);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) done = 1;
        end
        bready <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        bit done = 0;
        exp_r.push_back(e);
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge CLK);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) done = 1;
        end
        rready <= 1'b0;
        #1;
    endtask : rd

    // Response watcher: oldest note against each answer
    always @(posedge CLK) begin
        if (rvalid && rready) begin
            exp_v = exp_r.pop_front();
            `CHK("rdata", exp_v, {rresp, rdata})
        end
        if (bvalid && bready) begin
            exp_w = exp_b.pop_front();
            `CHK("bresp", exp_w, bresp)
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test

    // Watchdog
    initial begin
        repeat (20000) @(posedge CLK);
        err_total++;
        finish_test();
    end

    // Main sequence
    initial begin
        logic [15:0] v;
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(OFS_IDLE, {2'b00, 32'(RST_IDLE)});
        rd(OFS_PICKUP, {2'b00, 32'(RST_PICKUP)});
        rd(OFS_HOLD, {2'b00, 32'(RST_HOLD)});
        rd(OFS_HARM, {2'b00, 32'(RST_HARM)});
        rd(OFS_STATUS, 34'h0);
        rd(8'h30, {2'b10, 32'h0});
        wr(OFS_IDLE, 32'h0000_0020, 2'b10);
        rd(OFS_IDLE, {2'b00, 32'(RST_IDLE)});
        wr(8'h30, 32'h0000_0001, 2'b10);
        wr(OFS_CTRL, 32'h0000_0001, 2'b00);
        wr(OFS_SCALE, 32'h0000_0003, 2'b00);
        rd(OFS_IDLE_A, 34'h30);
        rd(OFS_PICK_A, 34'h300);
        $display("test registers done");
        for (int ph = 0; ph < 3; ph++) begin
            v = 16'h0101 + 16'(xs() & 32'h0000_0FFF);
            put(ph, v);
            cyc(4);
            `CHK("rise", 6'h3F, det_vec)
            rd(OFS_MAXCUR, {2'b00, 32'(v)});
            cyc(12);
            `CHK("harm", 6'h38, det_vec)
            rd(OFS_STATUS, 34'h1);
            put(ph, 16'h0100);
            cyc(4);
            `CHK("drop", 6'h00, det_vec)
            put(3, 16'h0000);
            cyc(4);
        end
        $display("test phases done");
        for (int i = 0; i < 5; i++) begin
            wr(OFS_HARM, 32'(thr_t[i]), 2'b00);
            cmd_harm <= hm_t[i];
            put(0, 16'h0200);
            cyc(4);
            `CHK("early", 6'h3F, det_vec)
            cyc(12);
            `CHK("late", {3'b111, {3{i != 3}}}, det_vec)
            `CHK("same", (i != 3), det_vec[5:3] == det_vec[2:0])
            put(3, 16'h0000);
            cyc(4);
        end
        $display("test harmonics done");
        wr(OFS_IRQ_ST, 32'h0000_000F, 2'b00);
        wr(OFS_HOLD, 32'h0000_000A, 2'b00);
        put(1, 16'h0300);
        cyc(60);
        `CHK("trip", 6'h00, det_vec)
        rd(OFS_STATUS, 34'hA);
        rd(OFS_IRQ_ST, 34'hF);
        `CHK("irq_off", 1'b0, irq)
        wr(OFS_IRQ_MSK, 32'h0000_0002, 2'b00);
        cyc(2);
        `CHK("irq_on", 1'b1, irq)
        wr(OFS_IRQ_ST, 32'h0000_0002, 2'b00);
        cyc(2);
        `CHK("irq_clr", 1'b0, irq)
        rd(OFS_IRQ_ST, 34'hD);
        $display("test trip done");
        put(3, 16'h0000);
        cyc(4);
        put(0, 16'h0080);
        cyc(30);
        put(0, 16'h0200);
        cyc(4);
        `CHK("linger", 6'h00, det_vec)
        put(3, 16'h0000);
        cyc(4);
        put(0, 16'h0080);
        cyc(10);
        put(0, 16'h0200);
        cyc(4);
        `CHK("window", 6'h3F, det_vec)
        put(0, 16'h0080);
        cyc(4);
        `CHK("fall", 6'h00, det_vec)
        put(0, 16'h0200);
        cyc(4);
        `CHK("rearm", 6'h00, det_vec)
        $display("test window done");
        finish_test();
    end
endmodule : cold_load_inrush_detector_test

// ==== dv/phase_source_model.sv ====
// Phase current and harmonic source in front of the detector.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/1ps
module phase_source_model #(
    parameter int CYCLE_LEN = 8
) (
    input  wire logic             clk,
    input  wire logic [2:0][15:0] cmd_cur,
    input  wire logic [2:0][7:0]  cmd_harm,
    output logic      [15:0]      cur1,
    output logic      [15:0]      cur2,
    output logic      [15:0]      cur3,
    output logic      [7:0]       harm1,
    output logic      [7:0]       harm2,
    output logic      [7:0]       harm3,
    output logic                  harm_valid
);
    logic [2:0][15:0] last_r = '0;
    int               cnt_r  = 0;

    // One cycle of measurement delay; analysis restarts on a change
    always_ff @(posedge clk) begin
        last_r <= cmd_cur;
        {cur3, cur2, cur1} <= cmd_cur;
        {harm3, harm2, harm1} <= cmd_harm;
        harm_valid <= 1'b0;
        if (cmd_cur != last_r) begin
            cnt_r <= 0;
        end else if (cnt_r == CYCLE_LEN - 1) begin
            cnt_r <= 0;
            harm_valid <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule : phase_source_model

// ==== verilog/cold_load_inrush_detector.sv ====
// Cold load pick-up and inrush detector with AXI4-Lite settings.
// Assumes phase currents and harmonic ratios synchronous to CLK;
// HARM_VALID pulses once per full analysis cycle.
//
// Function
// - Arm after idle; start on pick-up within window
// - Hold until max time or current drops
// - Both detections drive output and blocking matrix
// - Inrush adds second harmonic over threshold
// - Zero threshold makes inrush equal cold load
// - Block on start before harmonic data ready
// - After first cycle keep only if harmonic
// - Supervise maximum of three phase currents
// - Status reads inactive, start or trip
// - Fixed 80 ms transition window
// - Settings: time, idle, pick-up, harmonic percent
// - Read-only primary scaled limits
// - Lingering over 80 ms gives no detection
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cold_load_inrush_detector
    import cold_load_pkg::*;
#(
    parameter int WIN_CYCLES = WINDOW_CYCLES,
    parameter int MSEC_CYCLES = MS_CYCLES
) (
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    input  wire logic [CUR_W-1:0]  PHASE1_CURRENT,
    input  wire logic [CUR_W-1:0]  PHASE2_CURRENT,
    input  wire logic [CUR_W-1:0]  PHASE3_CURRENT,
    input  wire logic [PCT_W-1:0]  PHASE1_HARM_PCT,
    input  wire logic [PCT_W-1:0]  PHASE2_HARM_PCT,
    input  wire logic [PCT_W-1:0]  PHASE3_HARM_PCT,
    input  wire logic              HARM_VALID,
    output logic                   COLD_LOAD_DETECT,
    output logic                   INRUSH_DETECT,
    output logic                   COLD_LOAD_OUT_MATRIX,
    output logic                   COLD_LOAD_BLOCK_MATRIX,
    output logic                   INRUSH_OUT_MATRIX,
    output logic                   INRUSH_BLOCK_MATRIX,
    output logic                   IRQ,
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [7:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);
    // Settings and bus state
    logic [CUR_W-1:0]  idle_r, idle_nxt, pick_r, pick_nxt;
    logic [TIME_W-1:0] hold_r, hold_nxt;
    logic [PCT_W-1:0]  harm_r, harm_nxt;
    logic [15:0]       scale_r, scale_nxt;
    logic [1:0]        lock_r, lock_nxt;
    logic [IRQ_W-1:0]  ist_r, ist_nxt, imsk_r, imsk_nxt;
    logic              aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt;
    logic              rv_r, rv_nxt;
    logic [7:0]        awa_r, awa_nxt;
    logic [31:0]       wd_r, wd_nxt, rd_r, rd_nxt;
    logic [1:0]        br_r, br_nxt, rr_r, rr_nxt;
    // Detector state
    arm_state_t        arm_r, arm_nxt;
    logic [31:0]       win_r, win_nxt;
    logic [31:0]       ms_r, ms_nxt;
    logic [TIME_W-1:0] held_r, held_nxt;
    det_status_t       cl_r, cl_nxt, ir_r, ir_nxt;
    logic              harm_seen_r, harm_seen_nxt;
    logic [CUR_W-1:0]  imax;
    logic              all_idle, over_pick, harm_any, start_evt;
    logic [IRQ_W-1:0]  evt;
    // Supervised quantity is the largest phase
    always_comb begin
        imax = PHASE1_CURRENT;
        if (PHASE2_CURRENT > imax) imax = PHASE2_CURRENT;
        if (PHASE3_CURRENT > imax) imax = PHASE3_CURRENT;
    end
    assign all_idle  = (PHASE1_CURRENT < idle_r) && (PHASE2_CURRENT < idle_r)
                     && (PHASE3_CURRENT < idle_r);
    assign over_pick = imax > pick_r;
    // Each phase ratio compared on its own, then ORed
    assign harm_any = (PHASE1_HARM_PCT > harm_r) ||
                      (PHASE2_HARM_PCT > harm_r) ||
                      (PHASE3_HARM_PCT > harm_r);
    assign start_evt = (arm_r == ARM_RISE) && over_pick &&
                       (win_r < WIN_CYCLES);
    // Arming, transition window and hold timing
    always_comb begin
        arm_nxt = arm_r;
        win_nxt = win_r;
        ms_nxt = ms_r;
        held_nxt = held_r;
        cl_nxt = cl_r;
        ir_nxt = ir_r;
        harm_seen_nxt = harm_seen_r;
        case (arm_r)
            ARM_WAIT: if (all_idle) arm_nxt = ARM_IDLE;
            ARM_IDLE: if (!all_idle) begin
                arm_nxt = ARM_RISE;
                win_nxt = 32'd0;
            end
            ARM_RISE: begin
                if (all_idle) arm_nxt = ARM_IDLE;
                else if (start_evt) arm_nxt = ARM_SPENT;
                else if (win_r >= WIN_CYCLES) arm_nxt = ARM_SPENT;
                else win_nxt = win_r + 32'd1;
            end
            ARM_SPENT: if (all_idle) arm_nxt = ARM_IDLE;
            default: arm_nxt = ARM_WAIT;
        endcase
        if (start_evt) begin
            cl_nxt = ST_START;
            ir_nxt = ST_START;
            held_nxt = '0;
            ms_nxt = 32'd0;
            harm_seen_nxt = 1'b0;
        end else if (cl_r == ST_START) begin
            ms_nxt = (ms_r >= MSEC_CYCLES - 1) ? 32'd0 : ms_r + 32'd1;
            if (ms_r >= MSEC_CYCLES - 1) held_nxt = held_r + TIME_W'(1);
            if (!over_pick) begin
                cl_nxt = ST_INACTIVE;
                ir_nxt = ST_INACTIVE;
            end else if (held_r >= hold_r) begin
                cl_nxt = ST_TRIP;
                if (ir_r == ST_START) ir_nxt = ST_TRIP;
            end else if (HARM_VALID && !harm_seen_r) begin
                harm_seen_nxt = 1'b1;
                // Zero threshold makes inrush follow cold load
                if (!harm_any && harm_r != '0)
                    ir_nxt = ST_INACTIVE;
            end
        end else if (!over_pick) begin
            cl_nxt = ST_INACTIVE;
            ir_nxt = ST_INACTIVE;
        end
    end
    // Detector state registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            arm_r <= ARM_WAIT;
            win_r <= '0;
            ms_r <= '0;
            held_r <= '0;
            cl_r <= ST_INACTIVE;
            ir_r <= ST_INACTIVE;
            harm_seen_r <= 1'b0;
        end else begin
            arm_r <= arm_nxt;
            win_r <= win_nxt;
            ms_r <= ms_nxt;
            held_r <= held_nxt;
            cl_r <= cl_nxt;
            ir_r <= ir_nxt;
            harm_seen_r <= harm_seen_nxt;
        end
    end
    // Detection outputs to both matrices
    assign COLD_LOAD_DETECT       = (cl_r == ST_START);
    assign INRUSH_DETECT          = (ir_r == ST_START);
    assign COLD_LOAD_OUT_MATRIX   = COLD_LOAD_DETECT;
    assign COLD_LOAD_BLOCK_MATRIX = COLD_LOAD_DETECT;
    assign INRUSH_OUT_MATRIX      = INRUSH_DETECT;
    assign INRUSH_BLOCK_MATRIX    = INRUSH_DETECT;
    // Status events for interrupts
    assign evt[IRQ_CL_START] = (cl_nxt == ST_START) && (cl_r != ST_START);
    assign evt[IRQ_CL_TRIP]  = (cl_nxt == ST_TRIP) && (cl_r != ST_TRIP);
    assign evt[IRQ_IR_START] = (ir_nxt == ST_START) && (ir_r != ST_START);
    assign evt[IRQ_IR_TRIP]  = (ir_nxt == ST_TRIP) && (ir_r != ST_TRIP);
    assign IRQ = |(ist_r & imsk_r);
    // AXI4-Lite slave: write path, read path, settings
    always_comb begin
        aw_nxt = aw_r;
        w_nxt = w_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        bv_nxt = bv_r;
        br_nxt = br_r;
        rv_nxt = rv_r;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        idle_nxt = idle_r;
        pick_nxt = pick_r;
        hold_nxt = hold_r;
        harm_nxt = harm_r;
        scale_nxt = scale_r;
        lock_nxt = lock_r;
        imsk_nxt = imsk_r;
        ist_nxt = ist_r;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_nxt = 1'b1;
            awa_nxt = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_nxt = 1'b1;
            wd_nxt = S_AXI_WDATA & {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                                    {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
        end
        if (aw_r && w_r && !bv_r) begin
            aw_nxt = 1'b0;
            w_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = 2'b00;
            // Protected settings need the unlock bit
            if (awa_r == OFS_CTRL) lock_nxt = wd_r[1:0];
            else if (awa_r == OFS_IRQ_MSK) imsk_nxt = wd_r[IRQ_W-1:0];
            else if (awa_r == OFS_IRQ_ST) ist_nxt = ist_r & ~wd_r[IRQ_W-1:0];
            else if (awa_r == OFS_IDLE && lock_r[0])
                idle_nxt = wd_r[CUR_W-1:0];
            else if (awa_r == OFS_PICKUP && lock_r[0])
                pick_nxt = wd_r[CUR_W-1:0];
            else if (awa_r == OFS_HOLD && lock_r[0])
                hold_nxt = wd_r[TIME_W-1:0];
            else if (awa_r == OFS_HARM && lock_r[0])
                harm_nxt = wd_r[PCT_W-1:0];
            else if (awa_r == OFS_SCALE && lock_r[0])
                scale_nxt = wd_r[15:0];
            else br_nxt = 2'b10;
        end
        // Set wins over clear
        ist_nxt = ist_nxt | evt;
        if (bv_r && S_AXI_BREADY) bv_nxt = 1'b0;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rv_nxt = 1'b1;
            rr_nxt = 2'b00;
            rd_nxt = '0;
            if (S_AXI_ARADDR == OFS_CTRL) rd_nxt = {30'd0, lock_r};
            else if (S_AXI_ARADDR == OFS_IDLE) rd_nxt = {16'd0, idle_r};
            else if (S_AXI_ARADDR == OFS_PICKUP) rd_nxt = {16'd0, pick_r};
            else if (S_AXI_ARADDR == OFS_HOLD) rd_nxt = {16'd0, hold_r};
            else if (S_AXI_ARADDR == OFS_HARM) rd_nxt = {24'd0, harm_r};
            else if (S_AXI_ARADDR == OFS_SCALE) rd_nxt = {16'd0, scale_r};
            else if (S_AXI_ARADDR == OFS_STATUS)
                rd_nxt = {28'd0, ir_r, cl_r};
            else if (S_AXI_ARADDR == OFS_MAXCUR) rd_nxt = {16'd0, imax};
            else if (S_AXI_ARADDR == OFS_IDLE_A)
                rd_nxt = 32'(idle_r) * 32'(scale_r);
            else if (S_AXI_ARADDR == OFS_PICK_A)
                rd_nxt = 32'(pick_r) * 32'(scale_r);
            else if (S_AXI_ARADDR == OFS_IRQ_ST) rd_nxt = {28'd0, ist_r};
            else if (S_AXI_ARADDR == OFS_IRQ_MSK) rd_nxt = {28'd0, imsk_r};
            else rr_nxt = 2'b10;
        end else if (rv_r && S_AXI_RREADY) begin
            rv_nxt = 1'b0;
        end
    end
    // Ready from state, valid and data from registers
    assign S_AXI_AWREADY = !aw_r && !bv_r;
    assign S_AXI_WREADY  = !w_r && !bv_r;
    assign S_AXI_BVALID  = bv_r;
    assign S_AXI_BRESP   = br_r;
    assign S_AXI_ARREADY = !rv_r;
    assign S_AXI_RVALID  = rv_r;
    assign S_AXI_RDATA   = rd_r;
    assign S_AXI_RRESP   = rr_r;
    // Bus and settings registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            bv_r <= 1'b0;
            rv_r <= 1'b0;
            awa_r <= '0;
            wd_r <= '0;
            rd_r <= '0;
            br_r <= '0;
            rr_r <= '0;
            idle_r <= RST_IDLE;
            pick_r <= RST_PICKUP;
            hold_r <= RST_HOLD;
            harm_r <= RST_HARM;
            scale_r <= RST_SCALE;
            lock_r <= RST_LOCK;
            ist_r <= '0;
            imsk_r <= '0;
        end else begin
            aw_r <= aw_nxt;
            w_r <= w_nxt;
            bv_r <= bv_nxt;
            rv_r <= rv_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            br_r <= br_nxt;
            rr_r <= rr_nxt;
            idle_r <= idle_nxt;
            pick_r <= pick_nxt;
            hold_r <= hold_nxt;
            harm_r <= harm_nxt;
            scale_r <= scale_nxt;
            lock_r <= lock_nxt;
            ist_r <= ist_nxt;
            imsk_r <= imsk_nxt;
        end
    end
    // Checks
    a_start_needs_arm: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(COLD_LOAD_DETECT) |-> $past(arm_r) == ARM_RISE)
        else $error("cold load start without arming");
    a_drop_release: assert property (@(posedge CLK) disable iff (SYS_RST)
        (cl_r == ST_START && !over_pick && !start_evt) |=> !COLD_LOAD_DETECT)
        else $error("cold load held after current drop");
    a_matrix_follow: assert property (@(posedge CLK) disable iff (SYS_RST)
        INRUSH_BLOCK_MATRIX == INRUSH_DETECT &&
        COLD_LOAD_OUT_MATRIX == COLD_LOAD_DETECT)
        else $error("matrix output mismatch");
    a_inrush_early: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(COLD_LOAD_DETECT) |-> INRUSH_DETECT)
        else $error("inrush not raised with cold load start");
    a_zero_thresh: assert property (@(posedge CLK) disable iff (SYS_RST)
        (harm_r == '0 && $past(harm_r) == '0 && $past(harm_r, 2) == '0)
        |-> INRUSH_DETECT == COLD_LOAD_DETECT)
        else $error("inrush differs at zero threshold");
    a_harm_release: assert property (@(posedge CLK) disable iff (SYS_RST)
        (cl_r == ST_START && over_pick && held_r < hold_r && !start_evt &&
         HARM_VALID && !harm_seen_r && !harm_any && harm_r != '0)
        |=> !INRUSH_DETECT)
        else $error("inrush kept without harmonic");
    a_window_limit: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(COLD_LOAD_DETECT) |-> $past(win_r) < WIN_CYCLES)
        else $error("start after transition window");
    a_status_code: assert property (@(posedge CLK) disable iff (SYS_RST)
        cl_r != 2'b11 && ir_r != 2'b11)
        else $error("illegal status code");
endmodule : cold_load_inrush_detector

// ==== verilog/cold_load_pkg.sv ====
// Constants for the cold load and inrush detector.
// Assumes a 200 MHz system clock and an AXI4-Lite register port.
package cold_load_pkg;
    localparam int CLK_HZ         = 200_000_000;
    localparam int WINDOW_MS      = 80;
    localparam int WINDOW_CYCLES  = CLK_HZ / 1000 * WINDOW_MS;
    localparam int MS_CYCLES      = CLK_HZ / 1000;
    localparam int CUR_W          = 16;
    localparam int PCT_W          = 8;
    localparam int TIME_W         = 16;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_IDLE    = 8'h04;
    localparam logic [7:0] OFS_PICKUP  = 8'h08;
    localparam logic [7:0] OFS_HOLD    = 8'h0C;
    localparam logic [7:0] OFS_HARM    = 8'h10;
    localparam logic [7:0] OFS_SCALE   = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;
    localparam logic [7:0] OFS_MAXCUR  = 8'h1C;
    localparam logic [7:0] OFS_IDLE_A  = 8'h20;
    localparam logic [7:0] OFS_PICK_A  = 8'h24;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h28;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h2C;
    // Reset values
    localparam logic [CUR_W-1:0]  RST_IDLE   = 16'h0010;
    localparam logic [CUR_W-1:0]  RST_PICKUP = 16'h0100;
    localparam logic [TIME_W-1:0] RST_HOLD   = 16'h03E8;
    localparam logic [PCT_W-1:0]  RST_HARM   = 8'h0F;
    localparam logic [15:0]       RST_SCALE  = 16'h0001;
    localparam logic [1:0]        RST_LOCK   = 2'b00;
    // Interrupt bit positions
    localparam int IRQ_CL_START = 0;
    localparam int IRQ_CL_TRIP  = 1;
    localparam int IRQ_IR_START = 2;
    localparam int IRQ_IR_TRIP  = 3;
    localparam int IRQ_W        = 4;
    // Detector status encoding
    typedef enum logic [1:0] {
        ST_INACTIVE = 2'b00,
        ST_START    = 2'b01,
        ST_TRIP     = 2'b10
    } det_status_t;
    typedef enum logic [1:0] {
        ARM_WAIT  = 2'b00,
        ARM_IDLE  = 2'b01,
        ARM_RISE  = 2'b10,
        ARM_SPENT = 2'b11
    } arm_state_t;
endpackage : cold_load_pkg
